// >>> src/tsp_top.sv
// 8-bit timer with a prescaler shared with the watchdog
//
// The plain strobed port was left to the implementer.
module tsp_top
  import tsp_pkg::*;
#(
  parameter int PS_WIDTH = PS_WIDTH_DEF
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [7:0] busRdata,
  input wire logic extClockPin,
  input wire logic watchdogOsc,
  input wire logic clearWatchdogInstr,
  output logic watchdogTick,
  output logic watchdogClear,
  output logic intReq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] phase;
    logic pinSync1;
    logic pinSync2;
    logic wdSync1;
    logic wdSync2;
    logic smp;
    logic wdOutPrev;
    logic [7:0] count;
    logic [7:0] option;
    logic [7:0] interrupt_control;
    logic evtWd;
    logic maskWd;
    logic [7:0] rdata;
    logic wdTick;
    logic wdClr;
  } tsp_core_t;

  tsp_core_t q;
  tsp_core_t d;

  if (PS_WIDTH < PS_WIDTH_MIN) begin : g_chk
    $error("prescaler narrower than the largest rate tap");
  end

  // ---------------------------------------------------------------
  // shared prescaler
  // ---------------------------------------------------------------
  tsp_ps_if #(.WIDTH(PS_WIDTH)) psIf ();

  tsp_prescaler #(.WIDTH(PS_WIDTH)) u_prescaler (
    .mclk(mclk),
    .arst_n(arst_n),
    .ps(psIf.counter)
  );

  // ---------------------------------------------------------------
  // decode and clock paths
  // ---------------------------------------------------------------
  logic psToWd;
  logic [2:0] rate;
  logic instrLvl;
  logic extLvl;
  logic timerSrc;
  logic timerOut;
  logic wdOut;
  logic sampleNow;
  logic wrCount;
  logic incr;

  assign psToWd = q.option[OPT_PSA];
  assign rate = q.option[OPT_RATE_LSB +: OPT_RATE_W];
  // high in phases three and four: one rise per instruction cycle
  assign instrLvl = q.phase[1];
  // inverting the pin turns a falling edge into a rising one
  assign extLvl = q.pinSync2 ^ q.option[OPT_SE];
  assign timerSrc = q.option[OPT_CS] ? extLvl : instrLvl;

  // only one of the two sources may feed the counter
  assign psIf.inLevel = psToWd ? q.wdSync2 : timerSrc;

  // the unowned side bypasses the counter entirely
  always_comb begin
    if (psToWd) begin
      timerOut = timerSrc;
    end else begin
      timerOut = psIf.count[rate];
    end
  end

  always_comb begin
    if (!psToWd || rate == 3'h0) begin
      wdOut = q.wdSync2;
    end else begin
      wdOut = psIf.count[rate - 3'h1];
    end
  end

  assign sampleNow = (q.phase == PH_TWO) || (q.phase == PH_FOUR);
  assign wrCount = busWr && (busAddr == OFS_COUNT);
  // a count write in the same cycle wins over an increment
  assign incr = sampleNow && timerOut && !q.smp && !wrCount;

  // clears only through side effects, no software path to the count
  assign psIf.clear = (wrCount && !psToWd) ||
                      (clearWatchdogInstr && psToWd);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.phase = q.phase + 2'h1;
    d.pinSync1 = extClockPin;
    d.pinSync2 = q.pinSync1;
    d.wdSync1 = watchdogOsc;
    d.wdSync2 = q.wdSync1;
    d.wdOutPrev = wdOut;
    d.wdTick = wdOut && !q.wdOutPrev;
    d.wdClr = clearWatchdogInstr;
    if (sampleNow) begin
      d.smp = timerOut;
    end

    // software writes first, so that hardware sets below win
    if (busWr) begin
      unique case (busAddr)
        OFS_COUNT: d.count = busWdata;
        OFS_OPTION: d.option = busWdata;
        OFS_INTERRUPT_CONTROL: d.interrupt_control = busWdata;
        OFS_EVT_STAT: begin
          if (busWdata[EVT_OVF]) begin
            d.interrupt_control[INTERRUPT_CONTROL_FLAG] = 1'h0;
          end
          if (busWdata[EVT_WD]) begin
            d.evtWd = 1'h0;
          end
        end
        OFS_EVT_MASK: begin
          d.interrupt_control[INTERRUPT_CONTROL_EN] = busWdata[EVT_OVF];
          d.maskWd = busWdata[EVT_WD];
        end
        default: begin
        end
      endcase
    end

    if (incr) begin
      d.count = q.count + 8'h01;
      if (q.count == COUNT_MAX) begin
        d.interrupt_control[INTERRUPT_CONTROL_FLAG] = 1'h1;
      end
    end
    if (wdOut && !q.wdOutPrev) begin
      d.evtWd = 1'h1;
    end

    // read data stand only in the cycle after the strobe
    d.rdata = 8'h00;
    if (busRd) begin
      unique case (busAddr)
        OFS_COUNT: d.rdata = q.count;
        OFS_OPTION: d.rdata = q.option;
        OFS_INTERRUPT_CONTROL: d.rdata = q.interrupt_control;
        OFS_EVT_STAT: begin
          d.rdata[EVT_OVF] = q.interrupt_control[INTERRUPT_CONTROL_FLAG];
          d.rdata[EVT_WD] = q.evtWd;
        end
        OFS_EVT_MASK: begin
          d.rdata[EVT_OVF] = q.interrupt_control[INTERRUPT_CONTROL_EN];
          d.rdata[EVT_WD] = q.maskWd;
        end
        OFS_STATE: begin
          d.rdata[ST_PSA] = psToWd;
          d.rdata[ST_SAMPLE] = q.smp;
        end
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.option <= OPTION_RST;
      q.interrupt_control <= INTERRUPT_CONTROL_RST;
      q.count <= COUNT_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign busRdata = q.rdata;
  assign watchdogTick = q.wdTick;
  assign watchdogClear = q.wdClr;
  assign intReq = (q.interrupt_control[INTERRUPT_CONTROL_FLAG] && q.interrupt_control[INTERRUPT_CONTROL_EN]) ||
                  (q.evtWd && q.maskWd);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_count_write;
    busWr && busAddr == OFS_COUNT;
  endsequence

  sequence s_wd_clear;
    clearWatchdogInstr && psToWd;
  endsequence

  sequence s_roll;
    incr && q.count == COUNT_MAX;
  endsequence

  // internal source, prescaler on the watchdog: one step per instruction cycle, always in its last phase
  property p_source_sel;
    !q.option[OPT_CS] && psToWd && incr |-> q.phase == PH_FOUR;
  endproperty
  a_source_sel: assert property (p_source_sel)
    else $error("timer source does not follow select bit");

  property p_edge_sel;
    q.option[OPT_CS] && psToWd && $rose(q.pinSync2) && sampleNow
      && !q.option[OPT_SE] |-> timerOut;
  endproperty
  a_edge_sel: assert property (p_edge_sel)
    else $error("rising edge mode does not pass pin rise");

  property p_owner;
    psToWd |-> psIf.inLevel == q.wdSync2;
  endproperty
  a_owner: assert property (p_owner)
    else $error("prescaler not fed by watchdog when assigned");

  property p_rate_tap;
    !psToWd |-> timerOut == psIf.count[rate];
  endproperty
  a_rate_tap: assert property (p_rate_tap)
    else $error("timer rate tap mismatch");

  property p_wd_rate;
    psToWd && rate != 3'h0 |-> wdOut == psIf.count[rate - 3'h1];
  endproperty
  a_wd_rate: assert property (p_wd_rate)
    else $error("watchdog rate tap mismatch");

  property p_bypass;
    psToWd && q.option[OPT_CS] |-> timerOut == extLvl;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("pin does not bypass prescaler");

  property p_sample_phase;
    incr |-> sampleNow ##1 q.smp;
  endproperty
  a_sample_phase: assert property (p_sample_phase)
    else $error("count advanced outside sampling phase");

  property p_wd_unscaled;
    !psToWd |-> wdOut == q.wdSync2;
  endproperty
  a_wd_unscaled: assert property (p_wd_unscaled)
    else $error("watchdog prescaled while timer owns it");

  property p_write_clear;
    (s_count_write ##0 !psToWd) |=> psIf.count == '0 && $stable(psToWd);
  endproperty
  a_write_clear: assert property (p_write_clear)
    else $error("count write did not clear prescaler");

  property p_keep_assign;
    s_count_write |=> q.option == $past(q.option);
  endproperty
  a_keep_assign: assert property (p_keep_assign)
    else $error("count write changed option");

  property p_wd_clear;
    s_wd_clear |=> psIf.count == '0 && watchdogClear;
  endproperty
  a_wd_clear: assert property (p_wd_clear)
    else $error("clear-watchdog did not clear prescaler");

  property p_option_rw;
    busWr && busAddr == OFS_OPTION ##1 busRd && busAddr == OFS_OPTION
      && !busWr |=> busRdata == $past(busWdata, 2);
  endproperty
  a_option_rw: assert property (p_option_rw)
    else $error("option readback mismatch");

  property p_roll_flag;
    s_roll |=> q.count == 8'h00 && q.interrupt_control[INTERRUPT_CONTROL_FLAG];
  endproperty
  a_roll_flag: assert property (p_roll_flag)
    else $error("rollover did not set overflow flag");

  property p_flag_irq;
    q.interrupt_control[INTERRUPT_CONTROL_FLAG] && q.interrupt_control[INTERRUPT_CONTROL_EN] |-> intReq;
  endproperty
  a_flag_irq: assert property (p_flag_irq)
    else $error("enabled overflow flag raised no interrupt");

  property p_count_load;
    s_count_write |=> q.count == $past(busWdata);
  endproperty
  a_count_load: assert property (p_count_load)
    else $error("count write lost against an increment");

  property p_step_spacing;
    incr |=> !incr;
  endproperty
  a_step_spacing: assert property (p_step_spacing)
    else $error("count stepped on two adjacent cycles");

  property p_clear_echo;
    clearWatchdogInstr |=> watchdogClear;
  endproperty
  a_clear_echo: assert property (p_clear_echo)
    else $error("clear-watchdog not passed on to the watchdog");
endmodule // tsp_top

// >>> pkg/tsp_pkg.sv
// shared constants for the shared-prescaler timer block
package tsp_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT = 8'h01;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] OFS_OPTION = 8'h81;
  localparam logic [7:0] OFS_EVT_STAT = 8'h90;
  localparam logic [7:0] OFS_EVT_MASK = 8'h91;
  localparam logic [7:0] OFS_STATE = 8'h92;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int OPT_CS = 5;
  localparam int OPT_SE = 4;
  localparam int OPT_PSA = 3;
  localparam int OPT_RATE_LSB = 0;
  localparam int OPT_RATE_W = 3;
  localparam int INTERRUPT_CONTROL_EN = 5;
  localparam int INTERRUPT_CONTROL_FLAG = 2;
  localparam int EVT_OVF = 0;
  localparam int EVT_WD = 1;
  localparam int ST_PSA = 0;
  localparam int ST_SAMPLE = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  // ---------------------------------------------------------------
  // instruction cycle phases and prescaler size
  // ---------------------------------------------------------------
  localparam logic [1:0] PH_TWO = 2'h1;
  localparam logic [1:0] PH_FOUR = 2'h3;
  localparam int PS_WIDTH_DEF = 8;
  localparam int PS_WIDTH_MIN = 8;
endpackage

// >>> pkg/tsp_ps_if.sv
// carrier between the timer core and the shared prescaler counter
interface tsp_ps_if #(
  parameter int WIDTH = 8
);
  logic inLevel;
  logic clear;
  logic [WIDTH-1:0] count;
  modport owner (output inLevel, output clear, input count);
  modport counter (input inLevel, input clear, output count);
endinterface

// >>> src/tsp_prescaler.sv
// shared ripple-style prescaler counter, advanced on rising input
module tsp_prescaler
  import tsp_pkg::*;
#(
  parameter int WIDTH = PS_WIDTH_DEF
) (
  input wire logic mclk,
  input wire logic arst_n,
  tsp_ps_if.counter ps
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic prev;
    logic [WIDTH-1:0] count;
  } tsp_ps_state_t;

  tsp_ps_state_t q;
  tsp_ps_state_t d;

  if (WIDTH < PS_WIDTH_MIN) begin : g_chk
    $error("prescaler narrower than the largest rate tap");
  end

  // ---------------------------------------------------------------
  // counting
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.prev = ps.inLevel;
    // no load path: the count only clears or steps up by one
    if (ps.clear) begin
      d.count = '0;
    end else if (ps.inLevel && !q.prev) begin
      d.count = q.count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ps.count = q.count;
endmodule // tsp_prescaler

// >>> bench/tsp_ext_src.sv
// model of the clock source on the timer input pin
module tsp_ext_src (
  input wire logic mclk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  // 9 cycles a level, well above the two-sample minimum
  task automatic level(input logic v);
    @(posedge mclk);
    pin <= v;
    repeat (8) @(posedge mclk);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
endmodule // tsp_ext_src

// >>> bench/tb_top.sv
// self-checking bench for the shared-prescaler timer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tsp_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] busAddr = 8'h00;
  logic [7:0] busWdata = 8'h00;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic [7:0] busRdata;
  logic extClockPin;
  logic watchdogOsc = 1'b0;
  logic clearWatchdogInstr = 1'b0;
  logic watchdogTick;
  logic watchdogClear;
  logic intReq;
  logic [7:0] tickN = 8'h00;
  logic [7:0] clrN = 8'h00;
  int err_count = 0;
  int num_checks = 0;
  always #5 mclk = ~mclk;
  tsp_top uut (.mclk(mclk), .arst_n(arst_n), .busAddr(busAddr),
    .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
    .busRdata(busRdata), .extClockPin(extClockPin),
    .watchdogOsc(watchdogOsc), .clearWatchdogInstr(clearWatchdogInstr),
    .watchdogTick(watchdogTick), .watchdogClear(watchdogClear),
    .intReq(intReq));
  tsp_ext_src src (.mclk(mclk), .pin(extClockPin));
  always @(posedge mclk) begin
    if (watchdogTick === 1'b1) tickN <= tickN + 8'h01;
    if (watchdogClear === 1'b1) clrN <= clrN + 8'h01;
  end
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge mclk);
    busWr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge mclk);
    busRd <= 1'b0;
    #1 d = busRdata;
  endtask
  // write then read back with no idle cycle between the strobes
  task automatic wrrd(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    busAddr <= a;
    busWdata <= v;
    busWr <= 1'b1;
    @(posedge mclk);
    busWr <= 1'b0;
    busRd <= 1'b1;
    @(posedge mclk);
    busRd <= 1'b0;
    #1 cmp(busRdata, v);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    cmp(d, exp);
  endtask
  // reads are per*n cycles apart, so phase cancels out
  task automatic rate(input int per, input logic [7:0] n);
    logic [7:0] a;
    logic [7:0] b;
    rd(OFS_COUNT, a);
    cyc(per * n - 2);
    rd(OFS_COUNT, b);
    cmp(b - a, n);
  endtask
  task automatic osc(input int n);
    repeat (n) begin
      watchdogOsc <= 1'b1;
      cyc(8);
      watchdogOsc <= 1'b0;
      cyc(8);
    end
    cyc(4);
  endtask
  task automatic clr;
    @(posedge mclk);
    clearWatchdogInstr <= 1'b1;
    @(posedge mclk);
    clearWatchdogInstr <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    chk(OFS_OPTION, 8'hFF);
    chk(OFS_INTERRUPT_CONTROL, 8'h00);
    chk(8'h55, 8'h00);
    wr(OFS_OPTION, 8'h5A);
    chk(OFS_OPTION, 8'h5A);
    wrrd(OFS_OPTION, 8'hA5);
    $display("test regs done");
  endtask
  task automatic t_internal;
    wr(OFS_OPTION, 8'h08);
    rate(4, 8'd10);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_OPTION, 8'(c));
      wr(OFS_COUNT, 8'h00);
      chk(OFS_OPTION, 8'(c));
      rate(8 << c, 8'd4);
    end
    // slow rate shows whether a count write restarts the prescaler
    wr(OFS_COUNT, 8'h00);
    cyc(300);
    wr(OFS_COUNT, 8'h00);
    cyc(400);
    chk(OFS_COUNT, 8'h00);
    $display("test internal done");
  endtask
  task automatic t_pin;
    wr(OFS_OPTION, 8'h28);
    wr(OFS_COUNT, 8'h00);
    src.pulses(5);
    cyc(10);
    chk(OFS_COUNT, 8'h05);
    src.level(1'b1);
    cyc(10);
    chk(OFS_COUNT, 8'h06);
    wr(OFS_OPTION, 8'h38);
    wr(OFS_COUNT, 8'h00);
    cyc(10);
    chk(OFS_COUNT, 8'h00);
    src.level(1'b0);
    cyc(10);
    chk(OFS_COUNT, 8'h01);
    wr(OFS_OPTION, 8'h20);
    wr(OFS_COUNT, 8'h00);
    src.pulses(6);
    cyc(10);
    chk(OFS_COUNT, 8'h03);
    $display("test pin done");
  endtask
  task automatic t_overflow;
    wr(OFS_OPTION, 8'h08);
    wr(OFS_INTERRUPT_CONTROL, 8'h20);
    wr(OFS_COUNT, 8'hFE);
    cyc(12);
    cmp({7'h00, intReq}, 8'h01);
    chk(OFS_INTERRUPT_CONTROL, 8'h24);
    wr(OFS_INTERRUPT_CONTROL, 8'h04);
    cyc(2);
    cmp({7'h00, intReq}, 8'h00);
    wr(OFS_EVT_STAT, 8'h01);
    wr(OFS_INTERRUPT_CONTROL, 8'h20);
    cyc(2);
    cmp({7'h00, intReq}, 8'h00);
    chk(OFS_INTERRUPT_CONTROL, 8'h20);
    $display("test overflow done");
  endtask
  task automatic t_watchdog;
    logic [7:0] t0;
    logic [7:0] c0;
    wr(OFS_OPTION, 8'h00);
    t0 = tickN;
    osc(3);
    cmp(tickN - t0, 8'h03);
    // clear the count first so the hand-over makes no stray tick
    wr(OFS_COUNT, 8'h00);
    wr(OFS_OPTION, 8'h0B);
    c0 = clrN;
    clr();
    t0 = tickN;
    osc(3);
    clr();
    osc(3);
    cmp(tickN - t0, 8'h00);
    osc(5);
    cmp(tickN - t0, 8'h01);
    cmp(clrN - c0, 8'h02);
    chk(OFS_EVT_STAT, 8'h02);
    wr(OFS_EVT_MASK, 8'h02);
    cyc(2);
    cmp({7'h00, intReq}, 8'h01);
    chk(OFS_EVT_MASK, 8'h02);
    wr(OFS_EVT_STAT, 8'h02);
    cyc(2);
    cmp({7'h00, intReq}, 8'h00);
    wr(OFS_OPTION, 8'h28);
    cyc(4);
    chk(OFS_STATE, 8'h01);
    $display("test watchdog done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_internal();
    t_pin();
    t_overflow();
    t_watchdog();
    tally_and_finish();
  end
  initial begin
    #600us;
    err_count++;
    tally_and_finish();
  end
endmodule // tb_top
